// ==== design/cwbc_pkg.sv ====
// Shared constants and types for the co-simulation wrapper burst control
package cwbc_pkg;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  // Build-time burst selection and FIFO depth
  localparam bit BURST_EN = 1'b1;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = $clog2(FIFO_DEPTH);
  // Command operations
  localparam logic [1:0] OP_WR_INPUT = 2'h0;
  localparam logic [1:0] OP_RD_OUTPUT = 2'h1;
  localparam logic [1:0] OP_RUN = 2'h2;
  localparam logic [1:0] OP_RD_CLOCK = 2'h3;
  // Run arguments that select the free-running clock and stop the clock
  localparam logic [CNT_W-1:0] RUN_INF = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0] RUN_OFF = 32'h00000000;
  // Clock status codes
  localparam logic [1:0] STAT_STOPPED = 2'h0;
  localparam logic [1:0] STAT_COUNTING = 2'h1;
  localparam logic [1:0] STAT_FREE = 2'h2;
  // Pulse phases: two high, two low, one pulse every four ref cycles
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_HIGH_END = 2'h1;
  localparam logic [1:0] PH_RESET = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  typedef enum logic [1:0] {CWBC_STOPPED, CWBC_COUNTING, CWBC_FREE} cwbc_mode_e;
endpackage

// ==== design/cwbc_fifo.sv ====
// Synchronous FIFO used for burst-mode input and output registers
`timescale 1ns/1ps
`default_nettype none
module cwbc_fifo (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [cwbc_pkg::DATA_W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [cwbc_pkg::DATA_W-1:0] rd_data
);
  logic [cwbc_pkg::DATA_W-1:0] mem [cwbc_pkg::FIFO_DEPTH];
  logic [cwbc_pkg::FIFO_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [cwbc_pkg::FIFO_AW:0] count_reg, count_next;
  logic push, pop;

  always_comb begin
    push = wr_valid && wr_ready;
    pop = rd_valid && rd_ready;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + (cwbc_pkg::FIFO_AW+1)'(push) - (cwbc_pkg::FIFO_AW+1)'(pop);
  end

  assign wr_ready = count_reg != (cwbc_pkg::FIFO_AW+1)'(cwbc_pkg::FIFO_DEPTH);
  assign rd_valid = count_reg != '0;
  assign rd_data = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end
endmodule // cwbc_fifo
`default_nettype wire

// ==== design/cwbc_top.sv ====
// Command processor, register bank and clock control of the co-simulation wrapper
`timescale 1ns/1ps
`default_nettype none
module cwbc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [cwbc_pkg::DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [cwbc_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_err,
  output logic dut_clk,
  output logic [cwbc_pkg::DATA_W-1:0] dut_in,
  input wire logic [cwbc_pkg::DATA_W-1:0] dut_out
);
  ////////////////////////////////////////////////////////////////////////
  cwbc_pkg::cwbc_mode_e mode_reg, mode_next;
  logic [cwbc_pkg::CNT_W-1:0] left_reg, left_next;
  logic [1:0] phase_reg, phase_next;
  logic dut_clk_reg, dut_clk_next;
  logic [cwbc_pkg::DATA_W-1:0] dut_in_reg, dut_in_next;
  logic [cwbc_pkg::DATA_W-1:0] out_hold_reg, out_hold_next;
  logic [cwbc_pkg::DATA_W-1:0] out_s1_reg, out_s2_reg;
  logic rsp_valid_reg, rsp_valid_next;
  logic [cwbc_pkg::DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic rsp_err_reg, rsp_err_next;
  logic cmd_ready_reg, cmd_ready_next;
  logic take, pulse_end, pulse_fall, stall, run_ok;
  logic in_wr_valid, in_wr_ready, in_rd_valid, in_rd_ready;
  logic out_wr_valid, out_wr_ready, out_rd_valid, out_rd_ready;
  logic [cwbc_pkg::DATA_W-1:0] in_head, out_head;

  ////////////////////////////////////////////////////////////////////////
  // Burst-mode FIFOs replace the plain input and output registers
  cwbc_fifo u_in_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_valid(in_wr_valid),
    .wr_ready(in_wr_ready),
    .wr_data(cmd_data),
    .rd_valid(in_rd_valid),
    .rd_ready(in_rd_ready),
    .rd_data(in_head)
  );

  // Output FIFO is fed from the synchronised sample
  cwbc_fifo u_out_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wr_valid(out_wr_valid),
    .wr_ready(out_wr_ready),
    .wr_data(out_s2_reg),
    .rd_valid(out_rd_valid),
    .rd_ready(out_rd_ready),
    .rd_data(out_head)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock generator and capture
  // Pulse timeline, in ref_clk edges after a run is taken:
  //   edge 1: phase 0, rise of dut_clk
  //   edge 2: phase 1, dut_clk stays high
  //   edge 3: phase 2, fall, input FIFO pops, next stimulus registered one edge later
  //   edge 4: phase 3, low continues, output sample pushed, pulse counted
  //   edge 5: next rise while still running
  // The output sample needs two edges after the rise to pass the synchroniser,
  // which is why capture waits for the end of the low phase.
  always_comb begin
    take = cmd_valid && cmd_ready_reg;
    // A full output FIFO holds the clock so no sample is lost
    stall = cwbc_pkg::BURST_EN && !out_wr_ready;
    run_ok = (mode_reg != cwbc_pkg::CWBC_STOPPED) && !stall;
    pulse_end = run_ok && (phase_reg == cwbc_pkg::PH_LAST);
    mode_next = mode_reg;
    left_next = left_reg;
    phase_next = run_ok ? phase_reg + 2'h1 : cwbc_pkg::PH_RESET;
    pulse_fall = run_ok && (phase_reg == cwbc_pkg::PH_HIGH_END + 2'h1);
    // High for the two edges that leave the first half, so each pulse is two high and two low
    dut_clk_next = run_ok && (phase_reg <= cwbc_pkg::PH_HIGH_END);
    // The last pulse of a counted run stops the clock once its low phase ends
    if (pulse_end && mode_reg == cwbc_pkg::CWBC_COUNTING) begin
      left_next = left_reg - 1'b1;
      if (left_reg == 32'h00000001) begin
        mode_next = cwbc_pkg::CWBC_STOPPED;
      end
    end
    // A new run takes over at once and restarts the pulse phase
    if (take && cmd_op == cwbc_pkg::OP_RUN) begin
      phase_next = cwbc_pkg::PH_RESET;
      dut_clk_next = 1'b0;
      left_next = cmd_data;
      if (cmd_data == cwbc_pkg::RUN_OFF) begin
        mode_next = cwbc_pkg::CWBC_STOPPED;
      end else if (cmd_data == cwbc_pkg::RUN_INF) begin
        mode_next = cwbc_pkg::CWBC_FREE;
      end else begin
        mode_next = cwbc_pkg::CWBC_COUNTING;
      end
    end
    // Non-burst builds keep the last captured sample for single reads
    out_hold_next = pulse_end ? out_s2_reg : out_hold_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst pacing: one pop and one push per delivered pulse
  always_comb begin
    // Pop at the fall, so the next stimulus is registered a full cycle before the next rise
    in_rd_ready = cwbc_pkg::BURST_EN && pulse_fall;
    // Sample captured at the end of the low phase has settled through the synchroniser
    out_wr_valid = cwbc_pkg::BURST_EN && pulse_end;
  end

  ////////////////////////////////////////////////////////////////////////
  // Command processor
  always_comb begin
    in_wr_valid = 1'b0;
    out_rd_ready = 1'b0;
    dut_in_next = dut_in_reg;
    // Burst stimulus follows the input FIFO head and holds when it runs dry
    if (cwbc_pkg::BURST_EN && in_rd_valid) begin
      dut_in_next = in_head;
    end
    rsp_valid_next = rsp_valid_reg && !rsp_ready;
    rsp_data_next = rsp_data_reg;
    rsp_err_next = rsp_err_reg;
    if (take) begin
      rsp_valid_next = 1'b1;
      rsp_data_next = cwbc_pkg::DATA_RESET;
      rsp_err_next = 1'b0;
      unique case (cmd_op)
        cwbc_pkg::OP_WR_INPUT: begin
          if (cwbc_pkg::BURST_EN) begin
            // A full input FIFO drops the word and flags the response
            in_wr_valid = 1'b1;
            rsp_err_next = !in_wr_ready;
          end else begin
            dut_in_next = cmd_data;
          end
        end
        cwbc_pkg::OP_RD_OUTPUT: begin
          if (cwbc_pkg::BURST_EN) begin
            // An empty output FIFO flags the response; its data is then meaningless
            out_rd_ready = 1'b1;
            rsp_data_next = out_head;
            rsp_err_next = !out_rd_valid;
          end else begin
            rsp_data_next = out_hold_reg;
          end
        end
        cwbc_pkg::OP_RUN: begin
          rsp_data_next = cmd_data;
        end
        cwbc_pkg::OP_RD_CLOCK: begin
          // Upper bits of a status read are zero
          unique case (mode_reg)
            cwbc_pkg::CWBC_STOPPED: rsp_data_next = {30'h00000000, cwbc_pkg::STAT_STOPPED};
            cwbc_pkg::CWBC_COUNTING: rsp_data_next = {30'h00000000, cwbc_pkg::STAT_COUNTING};
            cwbc_pkg::CWBC_FREE: rsp_data_next = {30'h00000000, cwbc_pkg::STAT_FREE};
            default: rsp_data_next = {30'h00000000, cwbc_pkg::STAT_STOPPED};
          endcase
        end
      endcase
    end
    // One command in flight; next accepted only after the response is taken
    cmd_ready_next = !rsp_valid_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Two flops before the device_under_test output is read
  always_ff @(posedge ref_clk) begin
    out_s1_reg <= dut_out;
    out_s2_reg <= out_s1_reg;
  end

  // State registers; synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_reg <= cwbc_pkg::CWBC_STOPPED;
      left_reg <= '0;
      phase_reg <= cwbc_pkg::PH_RESET;
      dut_clk_reg <= 1'b0;
      dut_in_reg <= cwbc_pkg::DATA_RESET;
      out_hold_reg <= cwbc_pkg::DATA_RESET;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= cwbc_pkg::DATA_RESET;
      rsp_err_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      left_reg <= left_next;
      phase_reg <= phase_next;
      dut_clk_reg <= dut_clk_next;
      dut_in_reg <= dut_in_next;
      out_hold_reg <= out_hold_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_err_reg <= rsp_err_next;
      cmd_ready_reg <= cmd_ready_next;
    end
  end

  assign cmd_ready = cmd_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_err = rsp_err_reg;
  assign dut_clk = dut_clk_reg;
  assign dut_in = dut_in_reg;
endmodule // cwbc_top
`default_nettype wire

// ==== sim/cwbc_dut_model.sv ====
// Behavioural device_under_test: registers input plus one on each pulse
`timescale 1ns/1ps
`default_nettype none
module cwbc_dut_model (
  input wire logic clk,
  input wire logic [31:0] d,
  output logic [31:0] q
);
  initial q = 32'h00000000;
  always @(posedge clk) q <= d + 32'h00000001;
endmodule // cwbc_dut_model
`default_nettype wire

// ==== sim/cwbc_top_properties.sv ====
// Port checks for the wrapper top, bound below
`timescale 1ns/1ps
`default_nettype none
module cwbc_top_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [31:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_err,
  input wire logic dut_clk
);
  wire logic take = cmd_valid && cmd_ready;
  wire logic run_take = take && cmd_op == cwbc_pkg::OP_RUN;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RSP_NEXT: assert property (take |=> rsp_valid)
    else $error("no response");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response dropped");
  AST_ONE_OPEN: assert property (rsp_valid |-> !cmd_ready)
    else $error("ready while pending");
  AST_READY_BACK: assert property (rsp_valid && rsp_ready |=> !rsp_valid && cmd_ready)
    else $error("ready not back");
  AST_RUN_ECHO: assert property (run_take |=> rsp_data == $past(cmd_data))
    else $error("run echo wrong");
  // A run override resets the phase, so a shortened high is legal then
  AST_HIGH_TWO: assert property ($rose(dut_clk) && !run_take |=> dut_clk)
    else $error("short high");
  AST_LOW_TWO: assert property ($fell(dut_clk) && !$past(run_take) |=> !dut_clk)
    else $error("short low");
  AST_RUN_ONE: assert property (run_take && cmd_data == 32'h00000001 |-> ##2 dut_clk [*2] ##1 !dut_clk [*8])
    else $error("single pulse wrong");
  AST_CLOCK_OFF: assert property (run_take && cmd_data == cwbc_pkg::RUN_OFF |-> ##2 !dut_clk [*8])
    else $error("clock not off");
  cover property (run_take && cmd_data == cwbc_pkg::RUN_INF);
  cover property (rsp_valid && rsp_err);
  cover property (run_take && cmd_data == 32'h00000010);
endmodule // cwbc_top_properties
bind cwbc_top cwbc_top_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_err(rsp_err), .dut_clk(dut_clk));
`default_nettype wire

// ==== sim/test_cosim_wrapper_burst_control.sv ====
// Self-checking bench for the wrapper top
`timescale 1ns/1ps
`default_nettype none
module test_cosim_wrapper_burst_control;
  logic ref_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, rsp_ready = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [31:0] cmd_data = 32'h00000000;
  logic cmd_ready, rsp_valid, rsp_err, dut_clk, re;
  logic [31:0] rsp_data, dut_in, dut_out, rd;
  int n_mismatch = 0, checks = 0, pulses = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge dut_clk) pulses++;
  cwbc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .dut_clk(dut_clk), .dut_in(dut_in), .dut_out(dut_out));
  cwbc_dut_model model (.clk(dut_clk), .d(dut_in), .q(dut_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Response is left waiting one cycle so the hold behaviour gets exercised
  task automatic cmd(input logic [1:0] op, input logic [31:0] d);
    int n;
    cmd_op = op;
    cmd_data = d;
    cmd_valid = 1'b1;
    for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
    chk(32'(cmd_ready), 32'h00000001);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge ref_clk);
    chk(32'(rsp_valid), 32'h00000001);
    @(negedge ref_clk);
    rsp_ready = 1'b1;
    rd = rsp_data;
    re = rsp_err;
    @(negedge ref_clk);
    rsp_ready = 1'b0;
  endtask
  task automatic wait_stop;
    int n;
    for (n = 0; n < 30; n++) begin
      cmd(cwbc_pkg::OP_RD_CLOCK, 32'h00000000);
      if (rd === 32'(cwbc_pkg::STAT_STOPPED)) break;
    end
    chk(rd, 32'(cwbc_pkg::STAT_STOPPED));
  endtask
  task automatic t_step;
    int p;
    cmd(cwbc_pkg::OP_WR_INPUT, 32'h00000A5A);
    chk(dut_in, 32'h00000A5A);
    p = pulses;
    cmd(cwbc_pkg::OP_RUN, 32'h00000001);
    chk(rd, 32'h00000001);
    cmd(cwbc_pkg::OP_RD_CLOCK, 32'h00000000);
    chk(rd, 32'(cwbc_pkg::STAT_COUNTING));
    wait_stop();
    chk(32'(pulses - p), 32'h00000001);
    cmd(cwbc_pkg::OP_RD_OUTPUT, 32'h00000000);
    chk(rd, 32'h00000A5B);
  endtask
  // Overfill by one, run the whole depth, drain, then read past the end
  task automatic t_burst;
    int i, p;
    for (i = 0; i <= cwbc_pkg::FIFO_DEPTH; i++) begin
      cmd(cwbc_pkg::OP_WR_INPUT, 32'h00000100 + i);
      chk(32'(re), 32'(i == cwbc_pkg::FIFO_DEPTH));
    end
    chk(dut_in, 32'h00000100);
    p = pulses;
    cmd(cwbc_pkg::OP_RUN, 32'(cwbc_pkg::FIFO_DEPTH));
    wait_stop();
    chk(dut_in, 32'h0000010F);
    chk(32'(pulses - p), 32'(cwbc_pkg::FIFO_DEPTH));
    for (i = 0; i < cwbc_pkg::FIFO_DEPTH; i++) begin
      cmd(cwbc_pkg::OP_RD_OUTPUT, 32'h00000000);
      chk(rd, 32'h00000101 + i);
    end
    cmd(cwbc_pkg::OP_RD_OUTPUT, 32'h00000000);
    chk(32'(re), 32'h00000001);
  endtask
  task automatic t_free;
    int n, p;
    p = pulses;
    cmd(cwbc_pkg::OP_RUN, cwbc_pkg::RUN_INF);
    cmd(cwbc_pkg::OP_RD_CLOCK, 32'h00000000);
    chk(rd, 32'(cwbc_pkg::STAT_FREE));
    repeat (20) @(negedge ref_clk);
    cmd(cwbc_pkg::OP_RUN, cwbc_pkg::RUN_OFF);
    chk(32'(pulses > p), 32'h00000001);
    p = pulses;
    repeat (40) @(negedge ref_clk);
    chk(32'(pulses), 32'(p));
    for (n = 0; n < 17 && re !== 1'b1; n++) cmd(cwbc_pkg::OP_RD_OUTPUT, 32'h00000000);
    chk(32'(re), 32'h00000001);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_step();
    t_burst();
    t_free();
    conclude();
  end
  initial begin
    #40000;
    n_mismatch++;
    conclude();
  end
endmodule // test_cosim_wrapper_burst_control
`default_nettype wire
